// *** uart_with_hunt_and_discard_test.sv ***
// Self-checking bench for the serial port block with its far-end device model.
// Assumes registers are reached by one-cycle strobes and read data lands one cycle later.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module uart_with_hunt_and_discard_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic serial_rx;
    logic serial_tx;
    logic rx_irq;
    logic tx_irq;
    logic [7:0] rd_v;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    uhd_uart dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .serial_rx(serial_rx),
        .serial_tx(serial_tx), .rx_irq(rx_irq), .tx_irq(tx_irq));
    uhd_peer peer (.sys_clk(sys_clk), .line_out(serial_rx), .line_in(serial_tx));

    initial forever #2 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole run needs well under 20000 cycles; a hang stops here.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge sys_clk);
        bus_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(negedge sys_clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge sys_clk);
        bus_rd = 1'b0;
        rd_v = bus_rdata;
    endtask

    task automatic wait_rx();
        for (int k = 0; k < 40 && rx_irq !== 1'b1; k++) @(negedge sys_clk);
        `CHK("rx wait", 1'b1, rx_irq)
    endtask

    task automatic wait_got(input int n);
        for (int k = 0; k < 800 && peer.n_got < n; k++) @(negedge sys_clk);
        `CHK("frames seen", n, peer.n_got)
    endtask

    task automatic tx_byte(input logic [7:0] d);
        rd(uhd_pkg::A_STAT);
        `CHK("tx room", 1'b1, rd_v[1])
        wr(uhd_pkg::A_TX, d);
    endtask

    task automatic t_reset();
        rd(uhd_pkg::A_CTRL);
        `CHK("ctrl reset", 8'h00, rd_v)
        rd(uhd_pkg::A_STAT);
        `CHK("status reset", 8'h02, rd_v)
        rd(16'hF000);
        `CHK("unmapped", 8'h00, rd_v)
        `CHK("irq reset", 2'h0, {rx_irq, tx_irq})
        wr(uhd_pkg::A_CTRL, 8'h40);
        rd(uhd_pkg::A_CTRL);
        `CHK("ctrl rw", 8'h40, rd_v)
        `CHK("tx irq on", 1'b1, tx_irq)
        wr(uhd_pkg::A_CTRL, 8'h00);
        repeat (3) @(negedge sys_clk);
        `CHK("tx irq off", 1'b0, tx_irq)
    endtask

    task automatic t_tx8();
        wr(uhd_pkg::A_BAUD_LO, 8'h01);
        peer.bit_clks = 32;
        tx_byte(8'hA5);
        repeat (200) @(negedge sys_clk);
        `CHK("idle when off", 1'b1, serial_tx)
        wr(uhd_pkg::A_CTRL, 8'h10);
        wait_got(1);
        `CHK("tx count", 1, peer.n_got)
        `CHK("tx 8 bit", 9'h0A5, peer.got_word)
        wr(uhd_pkg::A_BAUD_LO, 8'h00);
        peer.bit_clks = 16;
    endtask

    task automatic t_tx9();
        logic [8:0] e;
        peer.nbits = 9;
        for (int m = 1; m < 4; m++) begin
            wr(uhd_pkg::A_CTRL, 8'h90 | 8'(m));
            tx_byte(8'h3D);
            wait_got(m + 1);
            e = {(m == 1) ? ~^8'h3D : ((m == 2) ? ^8'h3D : 1'b1), 8'h3D};
            `CHK("tx 9 bit", e, peer.got_word)
        end
        peer.nbits = 8;
    endtask

    task automatic t_rx();
        wr(uhd_pkg::A_CTRL, 8'h10);
        peer.send(9'h05A, 8, 1'b1, -1);
        wait_rx();
        `CHK("rx irq", 1'b1, rx_irq)
        rd(uhd_pkg::A_STAT);
        `CHK("rx status", 8'h03, rd_v)
        rd(uhd_pkg::A_RX);
        `CHK("rx data", 8'h5A, rd_v)
        repeat (3) @(negedge sys_clk);
        `CHK("rx irq clear", 1'b0, rx_irq)
        peer.send(9'h0C3, 8, 1'b1, 2);
        wait_rx();
        rd(uhd_pkg::A_STAT);
        `CHK("noise", 8'h07, rd_v)
        rd(uhd_pkg::A_RX);
        `CHK("noisy data", 8'hC3, rd_v)
    endtask

    task automatic t_err();
        peer.send(9'h000, 8, 1'b0, -1);
        wait_rx();
        rd(uhd_pkg::A_STAT);
        `CHK("framing", 8'h0B, rd_v)
        rd(uhd_pkg::A_RX);
        wr(uhd_pkg::A_CTRL, 8'h11);
        peer.send(9'h13D, 9, 1'b1, -1);
        wait_rx();
        rd(uhd_pkg::A_STAT);
        `CHK("parity", 6'h13, rd_v[5:0])
        rd(uhd_pkg::A_RX);
        wr(uhd_pkg::A_CTRL, 8'h19);
        peer.send(9'h13D, 9, 1'b1, -1);
        repeat (40) @(negedge sys_clk);
        `CHK("discard irq", 1'b0, rx_irq)
        rd(uhd_pkg::A_STAT);
        `CHK("discard", 1'b0, rd_v[0])
    endtask

    task automatic t_ovr();
        wr(uhd_pkg::A_CTRL, 8'h10);
        peer.send(9'h011, 8, 1'b1, -1);
        peer.send(9'h022, 8, 1'b1, -1);
        peer.send(9'h033, 8, 1'b1, -1);
        repeat (5) @(negedge sys_clk);
        rd(uhd_pkg::A_STAT);
        `CHK("overrun", 2'h3, {rd_v[5], rd_v[0]})
        rd(uhd_pkg::A_RX);
        `CHK("first", 8'h11, rd_v)
        rd(uhd_pkg::A_RX);
        `CHK("second", 8'h22, rd_v)
        rd(uhd_pkg::A_STAT);
        `CHK("drained", 1'b0, rd_v[0])
    endtask

    task automatic t_hunt();
        wr(uhd_pkg::A_CTRL, 8'h37);
        peer.send(9'h011, 9, 1'b1, -1);
        repeat (40) @(negedge sys_clk);
        `CHK("hunt skip", 1'b0, rx_irq)
        peer.send(9'h122, 9, 1'b1, -1);
        wait_rx();
        `CHK("hunt irq", 1'b1, rx_irq)
        rd(uhd_pkg::A_STAT);
        `CHK("ninth bit", 2'h3, {rd_v[6], rd_v[0]})
        rd(uhd_pkg::A_RX);
        `CHK("hunt data", 8'h22, rd_v)
    endtask

    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_tx8();
        t_tx9();
        t_rx();
        t_err();
        t_ovr();
        t_hunt();
        end_of_test();
    end
endmodule

// *** uhd_fifo2.sv ***
// Two-entry buffer with valid and ready on both sides; head comes from a register.
// Assumes both sides run on the same clock as the buffer.
`timescale 1ns/10ps
module uhd_fifo2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
    } uhd_fifo_s;

    uhd_fifo_s st_r;
    uhd_fifo_s st_nxt;
    logic push;
    logic pop;
    logic [1:0] wr_at;

    // Entries shift toward slot 0 so the head is always a plain register.
    always_comb begin
        st_nxt = st_r;
        pop = (st_r.cnt != 2'h0) && out_ready;
        push = in_valid && (st_r.cnt != uhd_pkg::FIFO_D);
        wr_at = st_r.cnt;
        if (pop) begin
            for (int i = 0; i < 1; i++) begin
                st_nxt.mem[i] = st_r.mem[i + 1];
            end
            wr_at = st_r.cnt - 2'h1;
        end
        if (push) begin
            st_nxt.mem[wr_at[0]] = in_data;
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready = st_r.cnt != uhd_pkg::FIFO_D;
    assign out_valid = st_r.cnt != 2'h0;
    assign out_data = st_r.mem[0];

    a_fifo_depth: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_r.cnt == uhd_pkg::FIFO_D && !pop) |=> st_r.cnt == uhd_pkg::FIFO_D)
        else $error("full buffer lost an entry");
endmodule

// *** uhd_peer.sv ***
// Far-end serial device: sends frames into the block and collects the frames it sends out.
// Assumes the bench sets bit_clks and nbits before a frame starts.
`timescale 1ns/10ps
module uhd_peer (
    // Clock
    input wire logic sys_clk,
    // Line
    output logic line_out,
    input wire logic line_in
);
    int bit_clks = 16;
    int nbits = 8;
    int n_got = 0;
    logic [8:0] got_word = 9'h000;

    initial line_out = 1'b1;

    // Glitch_at names a data bit whose middle gets a one-clock spike, or -1 for a clean frame.
    task automatic send(input logic [8:0] w, input int nb, input logic stop, input int glitch_at);
        logic b;
        for (int i = 0; i < nb + 2; i++) begin
            b = (i == 0) ? 1'b0 : ((i <= nb) ? w[i-1] : stop);
            for (int c = 0; c < bit_clks; c++) begin
                @(negedge sys_clk);
                line_out = (glitch_at >= 0 && i - 1 == glitch_at && c == 10) ? ~b : b;
            end
        end
        @(negedge sys_clk);
        line_out = 1'b1;
    endtask

    // Counts only frames that end in a high stop bit, so a short or missing stop shows up.
    always begin
        @(negedge line_in);
        got_word = 9'h000;
        repeat (bit_clks / 2) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge sys_clk);
            got_word[i] = line_in;
        end
        repeat (bit_clks) @(posedge sys_clk);
        if (line_in === 1'b1) n_got++;
    end
endmodule

// *** uhd_pkg.sv ***
// Constants, state encodings and the state record of the serial port block.
// Assumes one system clock and a byte-wide processor register port.
// Functional notes
// - Two mode bits select 8 bit, odd parity, even parity or 9-bit data frames.
// - Sampling tick comes from dividing the system clock by the baud code plus one; bit is 16 ticks.
// - Three mid-bit samples; any disagreement sets noise for the rest of the character.
// - Receive and transmit buffers each hold two characters.
// - A received character that finds the receive buffer full sets overrun.
// - A stop bit sampled low marks the character with a framing error.
// - With discard set, characters with framing, parity or noise errors are dropped.
// - Receive interrupt is high while a character waits and falls once it is read.
// - Transmit interrupt is high while the transmit buffer has room, gated by its enable.
// - Hunt in 9-bit data mode ignores bytes until the ninth bit equals the match bit.
// - In 9-bit data mode control bit 7 is sent as the ninth bit.
// - Nothing is sent or received while the enable bit is clear.
// - A line held low yields one framing-error character per character time.
// - Status shows ninth bit, overrun, parity, framing, noise, room to send, data ready.
package uhd_pkg;
    localparam logic [15:0] A_TX = 16'hF114;
    localparam logic [15:0] A_CTRL = 16'hF116;
    localparam logic [15:0] A_BAUD_LO = 16'hF118;
    localparam logic [15:0] A_BAUD_HI = 16'hF119;
    localparam logic [15:0] A_RX = 16'hF21C;
    localparam logic [15:0] A_STAT = 16'hF21E;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h0000;

    localparam int C_MATCH = 2;
    localparam int C_DROP = 3;
    localparam int C_EN = 4;
    localparam int C_HUNT = 5;
    localparam int C_TXIE = 6;
    localparam int C_TX9 = 7;

    localparam logic [1:0] M_8N = 2'h0;
    localparam logic [1:0] M_ODD = 2'h1;
    localparam logic [1:0] M_EVEN = 2'h2;
    localparam logic [1:0] M_DATA = 2'h3;

    localparam logic [3:0] PH_S0 = 4'h7;
    localparam logic [3:0] PH_S1 = 4'h8;
    localparam logic [3:0] PH_S2 = 4'h9;
    localparam logic [3:0] PH_END = 4'hF;
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;

    localparam int RE_B9 = 8;
    localparam int RE_PE = 9;
    localparam int RE_FE = 10;
    localparam int RE_NE = 11;
    localparam int RX_W = 12;
    localparam int TX_W = 8;
    localparam logic [1:0] FIFO_D = 2'h2;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } uhd_rx_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } uhd_tx_e;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] baud;
        logic [7:0] rdata;
        logic [15:0] div;
        logic rx_s1;
        logic rx_s2;
        uhd_rx_e rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_cnt;
        logic [8:0] rx_sh;
        logic [1:0] rx_smp;
        logic rx_ne;
        logic ovr;
        uhd_tx_e tx_st;
        logic [3:0] tx_ph;
        logic [3:0] tx_cnt;
        logic [8:0] tx_sh;
        logic tx_pin;
        logic rx_irq;
        logic tx_irq;
    } uhd_state_s;

    localparam uhd_state_s ST_RESET = '{
        ctrl: CTRL_RST,
        baud: BAUD_RST,
        rdata: 8'h00,
        div: 16'h0000,
        rx_s1: 1'b1,
        rx_s2: 1'b1,
        rx_st: RX_IDLE,
        rx_ph: 4'h0,
        rx_cnt: 4'h0,
        rx_sh: 9'h000,
        rx_smp: 2'h3,
        rx_ne: 1'b0,
        ovr: 1'b0,
        tx_st: TX_IDLE,
        tx_ph: 4'h0,
        tx_cnt: 4'h0,
        tx_sh: 9'h000,
        tx_pin: 1'b1,
        rx_irq: 1'b0,
        tx_irq: 1'b0
    };
endpackage

// *** uhd_uart.sv ***
// Serial port with two-character buffers, error flags, discard and ninth-bit hunt.
// Assumes a byte-wide register port on the system clock; the line input is asynchronous.
`timescale 1ns/10ps
module uhd_uart (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Processor register port
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Serial line
    input wire logic serial_rx,
    output logic serial_tx,
    // Interrupt requests
    output logic rx_irq,
    output logic tx_irq
);
    uhd_pkg::uhd_state_s st_r;
    uhd_pkg::uhd_state_s st_nxt;

    logic rxf_in_valid;
    logic rxf_in_ready;
    logic rxf_out_valid;
    logic rxf_pop;
    logic [uhd_pkg::RX_W-1:0] rxf_in_data;
    logic [uhd_pkg::RX_W-1:0] rxf_out_data;
    logic txf_push;
    logic txf_in_ready;
    logic txf_out_valid;
    logic txf_pop;
    logic [uhd_pkg::TX_W-1:0] txf_out_data;

    logic tick;
    logic en;
    logic hunt_on;
    logic smp_maj;
    logic smp_dis;
    logic dlv;
    logic dlv_drop;
    logic pe;
    logic fe;
    logic ne;
    logic rx_b9;
    logic tx9;
    logic [2:0] smp;
    logic [1:0] mode;
    logic [3:0] last_bit;
    logic [7:0] rx_byte;
    logic [7:0] stat;

    uhd_fifo2 #(
        .W(uhd_pkg::RX_W)
    ) u_rx_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(rxf_in_valid),
        .in_data(rxf_in_data),
        .in_ready(rxf_in_ready),
        .out_valid(rxf_out_valid),
        .out_data(rxf_out_data),
        .out_ready(rxf_pop)
    );

    uhd_fifo2 #(
        .W(uhd_pkg::TX_W)
    ) u_tx_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(txf_push),
        .in_data(bus_wdata),
        .in_ready(txf_in_ready),
        .out_valid(txf_out_valid),
        .out_data(txf_out_data),
        .out_ready(txf_pop)
    );

    always_comb begin
        st_nxt = st_r;
        mode = st_r.ctrl[1:0];
        en = st_r.ctrl[uhd_pkg::C_EN];
        hunt_on = st_r.ctrl[uhd_pkg::C_HUNT] && (mode == uhd_pkg::M_DATA);
        last_bit = (mode == uhd_pkg::M_8N) ? uhd_pkg::LAST8 : uhd_pkg::LAST9;

        // The divider counts 0..code, so the tick period is code + 1 clocks. Comparing with
        // greater-or-equal keeps a lowered code from waiting for the counter to wrap.
        tick = en && (st_r.div >= st_r.baud);
        st_nxt.div = (!en || tick) ? 16'h0000 : st_r.div + 16'h0001;

        smp = {st_r.rx_smp, st_r.rx_s2};
        smp_maj = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
        smp_dis = (smp != 3'h0) && (smp != 3'h7);
        rx_byte = (mode == uhd_pkg::M_8N) ? st_r.rx_sh[8:1] : st_r.rx_sh[7:0];
        rx_b9 = (mode == uhd_pkg::M_8N) ? 1'b0 : st_r.rx_sh[8];
        pe = ((mode == uhd_pkg::M_ODD) && (rx_b9 == ^rx_byte))
            || ((mode == uhd_pkg::M_EVEN) && (rx_b9 != ^rx_byte));
        fe = !smp_maj;
        ne = st_r.rx_ne || smp_dis;

        // A character is handed over at the stop bit's third mid-bit sample.
        dlv = tick && (st_r.rx_st == uhd_pkg::RX_STOP) && (st_r.rx_ph == uhd_pkg::PH_S2);
        dlv_drop = (st_r.ctrl[uhd_pkg::C_DROP] && (pe || fe || ne))
            || (hunt_on && (rx_b9 != st_r.ctrl[uhd_pkg::C_MATCH]));
        rxf_in_valid = dlv && !dlv_drop;
        rxf_in_data = {ne, fe, pe, rx_b9, rx_byte};
        rxf_pop = bus_rd && (bus_addr == uhd_pkg::A_RX);
        txf_push = bus_wr && (bus_addr == uhd_pkg::A_TX);
        txf_pop = 1'b0;

        case (mode)
            uhd_pkg::M_ODD: tx9 = ~^txf_out_data;
            uhd_pkg::M_EVEN: tx9 = ^txf_out_data;
            uhd_pkg::M_DATA: tx9 = st_r.ctrl[uhd_pkg::C_TX9];
            default: tx9 = 1'b0;
        endcase

        // Receive line synchroniser.
        st_nxt.rx_s1 = serial_rx;
        st_nxt.rx_s2 = st_r.rx_s1;

        if (tick) begin
            st_nxt.rx_ph = st_r.rx_ph + 4'h1;
            if (st_r.rx_ph == uhd_pkg::PH_S0 || st_r.rx_ph == uhd_pkg::PH_S1) begin
                st_nxt.rx_smp = {st_r.rx_smp[0], st_r.rx_s2};
            end
            case (st_r.rx_st)
                uhd_pkg::RX_IDLE: begin
                    st_nxt.rx_ph = 4'h0;
                    // A low level starts a character even without an edge, so a
                    // line stuck low produces one character per character time.
                    if (!st_r.rx_s2) begin
                        st_nxt.rx_st = uhd_pkg::RX_START;
                        st_nxt.rx_ne = 1'b0;
                    end
                end
                uhd_pkg::RX_START: begin
                    if (st_r.rx_ph == uhd_pkg::PH_S2) begin
                        if (smp_maj) begin
                            st_nxt.rx_st = uhd_pkg::RX_IDLE;
                        end else begin
                            st_nxt.rx_ne = ne;
                        end
                    end
                    if (st_r.rx_ph == uhd_pkg::PH_END) begin
                        st_nxt.rx_st = uhd_pkg::RX_DATA;
                        st_nxt.rx_cnt = 4'h0;
                    end
                end
                uhd_pkg::RX_DATA: begin
                    if (st_r.rx_ph == uhd_pkg::PH_S2) begin
                        st_nxt.rx_sh = {smp_maj, st_r.rx_sh[8:1]};
                        st_nxt.rx_ne = ne;
                    end
                    if (st_r.rx_ph == uhd_pkg::PH_END) begin
                        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                        if (st_r.rx_cnt == last_bit) begin
                            st_nxt.rx_st = uhd_pkg::RX_STOP;
                        end
                    end
                end
                uhd_pkg::RX_STOP: begin
                    if (st_r.rx_ph == uhd_pkg::PH_S2) begin
                        st_nxt.rx_ne = ne;
                    end
                    // The whole stop bit is waited out before looking for a start.
                    if (st_r.rx_ph == uhd_pkg::PH_END) begin
                        st_nxt.rx_st = uhd_pkg::RX_IDLE;
                    end
                end
                default: begin
                    st_nxt.rx_st = uhd_pkg::RX_IDLE;
                end
            endcase
        end

        // Overrun clears when software reads a character, but a new overrun wins.
        if (rxf_pop) begin
            st_nxt.ovr = 1'b0;
        end
        if (rxf_in_valid && !rxf_in_ready) begin
            st_nxt.ovr = 1'b1;
        end
        // A matching byte ends the hunt so that the message body is received.
        if (dlv && hunt_on && (rx_b9 == st_r.ctrl[uhd_pkg::C_MATCH])) begin
            st_nxt.ctrl[uhd_pkg::C_HUNT] = 1'b0;
        end

        case (st_r.tx_st)
            uhd_pkg::TX_IDLE: begin
                st_nxt.tx_pin = 1'b1;
                if (en && txf_out_valid) begin
                    txf_pop = 1'b1;
                    st_nxt.tx_st = uhd_pkg::TX_START;
                    st_nxt.tx_ph = 4'h0;
                    st_nxt.tx_pin = 1'b0;
                    st_nxt.tx_sh = {tx9, txf_out_data};
                end
            end
            uhd_pkg::TX_START: begin
                if (tick) begin
                    st_nxt.tx_ph = st_r.tx_ph + 4'h1;
                    if (st_r.tx_ph == uhd_pkg::PH_END) begin
                        st_nxt.tx_st = uhd_pkg::TX_DATA;
                        st_nxt.tx_cnt = 4'h0;
                        st_nxt.tx_pin = st_r.tx_sh[0];
                    end
                end
            end
            uhd_pkg::TX_DATA: begin
                if (tick) begin
                    st_nxt.tx_ph = st_r.tx_ph + 4'h1;
                    if (st_r.tx_ph == uhd_pkg::PH_END) begin
                        st_nxt.tx_sh = {1'b1, st_r.tx_sh[8:1]};
                        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                        if (st_r.tx_cnt == last_bit) begin
                            st_nxt.tx_st = uhd_pkg::TX_STOP;
                            st_nxt.tx_pin = 1'b1;
                        end else begin
                            st_nxt.tx_pin = st_r.tx_sh[1];
                        end
                    end
                end
            end
            uhd_pkg::TX_STOP: begin
                if (tick) begin
                    st_nxt.tx_ph = st_r.tx_ph + 4'h1;
                    if (st_r.tx_ph == uhd_pkg::PH_END) begin
                        st_nxt.tx_st = uhd_pkg::TX_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.tx_st = uhd_pkg::TX_IDLE;
                st_nxt.tx_pin = 1'b1;
            end
        endcase

        // Disabling aborts any character in flight; buffered data is kept.
        if (!en) begin
            st_nxt.rx_st = uhd_pkg::RX_IDLE;
            st_nxt.rx_ph = 4'h0;
            st_nxt.tx_st = uhd_pkg::TX_IDLE;
            st_nxt.tx_pin = 1'b1;
        end

        st_nxt.rx_irq = rxf_out_valid;
        st_nxt.tx_irq = st_r.ctrl[uhd_pkg::C_TXIE] && txf_in_ready;

        stat = {1'b0,
            rxf_out_valid && rxf_out_data[uhd_pkg::RE_B9],
            st_r.ovr,
            rxf_out_valid && rxf_out_data[uhd_pkg::RE_PE],
            rxf_out_valid && rxf_out_data[uhd_pkg::RE_FE],
            rxf_out_valid && rxf_out_data[uhd_pkg::RE_NE],
            txf_in_ready,
            rxf_out_valid};

        st_nxt.rdata = 8'h00;
        if (bus_rd) begin
            case (bus_addr)
                uhd_pkg::A_CTRL: st_nxt.rdata = st_r.ctrl;
                uhd_pkg::A_STAT: st_nxt.rdata = stat;
                uhd_pkg::A_BAUD_LO: st_nxt.rdata = st_r.baud[7:0];
                uhd_pkg::A_BAUD_HI: st_nxt.rdata = st_r.baud[15:8];
                uhd_pkg::A_RX: st_nxt.rdata = rxf_out_data[7:0];
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // A software write to control overrides the hunt clear above.
        if (bus_wr) begin
            case (bus_addr)
                uhd_pkg::A_CTRL: st_nxt.ctrl = bus_wdata;
                uhd_pkg::A_BAUD_LO: st_nxt.baud[7:0] = bus_wdata;
                uhd_pkg::A_BAUD_HI: st_nxt.baud[15:8] = bus_wdata;
                default: st_nxt.baud = st_nxt.baud;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= uhd_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata = st_r.rdata;
    assign serial_tx = st_r.tx_pin;
    assign rx_irq = st_r.rx_irq;
    assign tx_irq = st_r.tx_irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tx_load;
        (st_r.tx_st == uhd_pkg::TX_IDLE) && txf_pop;
    endsequence

    sequence s_held_enabled;
        st_r.ctrl[uhd_pkg::C_EN] [*7];
    endsequence

    a_tx_start_low: assert property (s_tx_load ##1 s_held_enabled |-> !serial_tx)
        else $error("start bit ended too early");

    a_idle_line_high: assert property ((st_r.tx_st == uhd_pkg::TX_IDLE) |-> serial_tx)
        else $error("line not high while transmitter idle");

    a_disable_quiet: assert property (!en |=>
        (st_r.rx_st == uhd_pkg::RX_IDLE) && (st_r.tx_st == uhd_pkg::TX_IDLE))
        else $error("activity while disabled");

    a_overrun_flag: assert property ((rxf_in_valid && !rxf_in_ready) |=> st_r.ovr)
        else $error("overrun not flagged");

    a_discard_err: assert property ((dlv && st_r.ctrl[uhd_pkg::C_DROP]
        && (pe || fe || ne)) |-> !rxf_in_valid)
        else $error("bad character stored in discard mode");

    a_frame_err: assert property (dlv |->
        (rxf_in_data[uhd_pkg::RE_FE] == ($countones(smp) < 2)))
        else $error("framing flag does not match stop samples");

    a_tx_irq_gate: assert property (tx_irq |->
        $past(st_r.ctrl[uhd_pkg::C_TXIE]) && $past(txf_in_ready))
        else $error("transmit interrupt without enable or room");

    a_rx_irq_data: assert property (1'b1 |=> (rx_irq == $past(rxf_out_valid)))
        else $error("receive interrupt does not follow buffer state");

    a_noise_sticky: assert property ((st_r.rx_ne && (st_r.rx_st != uhd_pkg::RX_IDLE))
        |=> st_r.rx_ne)
        else $error("noise flag lost inside a character");

    a_hunt_drop: assert property ((dlv && hunt_on
        && (rx_b9 != st_r.ctrl[uhd_pkg::C_MATCH])) |-> !rxf_in_valid)
        else $error("byte accepted while hunting");

    a_tx_parity: assert property ((s_tx_load ##0 (mode == uhd_pkg::M_ODD))
        |=> ^st_r.tx_sh)
        else $error("odd parity wrong on transmit");
endmodule
